// >>> bzc_map.svh
`ifndef BZC_MAP_SVH
`define BZC_MAP_SVH

// ***************************************************
// Register offsets (byte addresses, one word each)
// ***************************************************
`define BZC_OFF_SP_ONE      8'h00
`define BZC_OFF_SP_TWO      8'h04
`define BZC_OFF_SP_THREE    8'h08
`define BZC_OFF_SP_FOUR     8'h0c
`define BZC_OFF_COLORS      8'h10
`define BZC_OFF_CONTROL     8'h14
`define BZC_OFF_STATUS      8'h18
`define BZC_OFF_POSITION    8'h1c

// ***************************************************
// Field positions and reset values
// ***************************************************
// Colors register: 2 bits per item, below-all in [1:0], then above first..fourth
`define BZC_COL_W           2
// Control register: [1:0] brightness, [2] tricolor fitted
`define BZC_CTL_TRI_BIT     2
`define BZC_CTL_RESET       3'h7
`define BZC_COLORS_RESET    10'h000
`define BZC_SP_RESET        16'h0000

`endif

// >>> bzc_pkg.sv
package bzc_pkg;
    // Bar color code
    typedef enum logic [1:0] {
        BZC_GREEN  = 2'h0,
        BZC_ORANGE = 2'h1,
        BZC_RED    = 2'h2
    } bzc_color_t;

    // Front-panel menu position
    typedef enum logic [3:0] {
        BZC_M_IDLE,
        BZC_M_BELOW,
        BZC_M_ABOVE1,
        BZC_M_ABOVE2,
        BZC_M_ABOVE3,
        BZC_M_ABOVE4
    } bzc_menu_t;
endpackage

// >>> bzc_zone_check.sv
`timescale 1ns/1ps
`include "bzc_map.svh"

// ***************************************************
// One setpoint compare: above only when strictly greater
// ***************************************************
module bzc_zone_check #(
    parameter int W = 16
) (
    // Values
    input  wire logic signed [W-1:0] position_i,
    input  wire logic signed [W-1:0] setpoint_i,
    // Result
    output logic                     above_o
);
    // Equality counts as below
    assign above_o = (position_i > setpoint_i);
endmodule // bzc_zone_check

// >>> bzc_color_selector.sv
`timescale 1ns/1ps
`include "bzc_map.svh"

// How it works
// - Whole bar shows exactly one color
// - Entering new zone switches whole bar color
// - Below lowest setpoint uses below-all color
// - Above color chosen by setpoint value
// - Equal setpoints: highest numbered color wins
// - Program key advances items, alternates label/color
// - Up/down step green, orange, red
// - Program after fifth color exits menu
// - Lockout allows viewing, refuses any change
// - Lockout, dim active when tied low
// - Dim halves selected brightness
// - Color menu only with tricolor fitted
module bzc_color_selector
    import bzc_pkg::*;
#(
    parameter int W        = 16,
    parameter int BLINK_CY = 12500000
) (
    // Clock and reset
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    // Wishbone slave
    input  wire logic              cyc_i,
    input  wire logic              stb_i,
    input  wire logic              we_i,
    input  wire logic [7:0]        adr_i,
    input  wire logic [3:0]        sel_i,
    input  wire logic [31:0]       dat_i,
    output logic      [31:0]       dat_o,
    output logic                   ack_o,
    // Bar position and update strobe
    input  wire logic signed [W-1:0] position_i,
    input  wire logic              update_i,
    // Front-panel keys, one-cycle pulses
    input  wire logic              key_prog_i,
    input  wire logic              key_up_i,
    input  wire logic              key_down_i,
    input  wire logic              relay_menu_done_i,
    // Rear contacts, low when tied to common
    input  wire logic              lock_n_i,
    input  wire logic              dim_n_i,
    // Display drive
    output logic      [1:0]        bar_color_o,
    output logic      [1:0]        brightness_o,
    output logic                   show_label_o,
    output logic      [2:0]        menu_item_o,
    output logic                   menu_active_o
);

    // ***************************************************
    // State
    // ***************************************************
    logic signed [W-1:0] sp_reg [4];
    logic [9:0]          colors_reg;
    logic [2:0]          ctl_reg;
    logic signed [W-1:0] pos_reg;
    bzc_menu_t           menu_reg;
    logic                label_reg;
    logic [3:0]          above;
    logic [1:0]          color_next;
    logic                locked;
    logic                dimmed;
    logic                bus_wr;
    logic                menu_wr;
    logic [2:0]          item;
    logic [31:0]         rd_next;

    assign locked = ~lock_n_i;
    assign dimmed = ~dim_n_i;

    // ***************************************************
    // Zone compare
    // ***************************************************
    // Latch bar once per update
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pos_reg <= '0;
        end else if (update_i) begin
            pos_reg <= position_i;
        end
    end

    // Signed compare: setpoints may sit below zero
    // Position grows rightward on horizontal bars
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_cmp
            bzc_zone_check #(.W(W)) u_cmp (
                .position_i (pos_reg),
                .setpoint_i (sp_reg[g]),
                .above_o    (above[g])
            );
        end
    endgenerate

    // Color of the highest-valued setpoint passed
    always_comb begin
        logic signed [W-1:0] best;
        logic                found;
        best       = '0;
        found      = 1'b0;
        color_next = colors_reg[1:0];
        for (int i = 0; i < 4; i++) begin
            // Later index wins on ties through >=
            if (above[i] && (!found || sp_reg[i] >= best)) begin
                best       = sp_reg[i];
                found      = 1'b1;
                color_next = colors_reg[2*i+2 +: 2];
            end
        end
    end

    // ***************************************************
    // Display drive
    // ***************************************************
    // A single registered code feeds every segment, so the
    // bar never shows two colors while a zone changes
    // One registered code for whole bar
    // Updates on the clock after the zone changes
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bar_color_o <= BZC_GREEN;
        end else begin
            bar_color_o <= color_next;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            brightness_o <= 2'h0;
        end else begin
            brightness_o <= dimmed ? {1'b0, ctl_reg[1]} : ctl_reg[1:0];
        end
    end

    // ***************************************************
    // Front-panel color menu
    // ***************************************************
    // Label/color alternate blink, a free slow toggle
    // Restarts on each program key so a new item opens on its label
    logic [31:0] blink_cnt;
    always_ff @(posedge clk_i) begin
        if (rst_i || key_prog_i || menu_reg == BZC_M_IDLE) begin
            blink_cnt <= '0;
            label_reg <= 1'b1;
        end else if (blink_cnt == 32'(BLINK_CY - 1)) begin
            blink_cnt <= '0;
            label_reg <= ~label_reg;
        end else begin
            blink_cnt <= blink_cnt + 32'h1;
        end
    end

    // Menu position; the relay step hands over to the color items
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            menu_reg <= BZC_M_IDLE;
        end else begin
            case (menu_reg)
                BZC_M_IDLE: begin
                    if (relay_menu_done_i && ctl_reg[`BZC_CTL_TRI_BIT]) begin
                        menu_reg <= BZC_M_BELOW;
                    end
                end
                BZC_M_BELOW:  if (key_prog_i) menu_reg <= BZC_M_ABOVE1;
                BZC_M_ABOVE1: if (key_prog_i) menu_reg <= BZC_M_ABOVE2;
                BZC_M_ABOVE2: if (key_prog_i) menu_reg <= BZC_M_ABOVE3;
                BZC_M_ABOVE3: if (key_prog_i) menu_reg <= BZC_M_ABOVE4;
                BZC_M_ABOVE4: if (key_prog_i) menu_reg <= BZC_M_IDLE;
                default:      menu_reg <= BZC_M_IDLE;
            endcase
        end
    end

    // Item index 0..4, colors field number
    always_comb begin
        case (menu_reg)
            BZC_M_BELOW:  item = 3'h0;
            BZC_M_ABOVE1: item = 3'h1;
            BZC_M_ABOVE2: item = 3'h2;
            BZC_M_ABOVE3: item = 3'h3;
            BZC_M_ABOVE4: item = 3'h4;
            default:      item = 3'h7;
        endcase
    end

    // Menu outputs, one edge behind the menu state
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            show_label_o  <= 1'b0;
            menu_item_o   <= 3'h0;
            menu_active_o <= 1'b0;
        end else begin
            show_label_o  <= (menu_reg != BZC_M_IDLE) && label_reg;
            menu_item_o   <= (menu_reg != BZC_M_IDLE) ? item : 3'h0;
            menu_active_o <= (menu_reg != BZC_M_IDLE);
        end
    end

    // ***************************************************
    // Wishbone slave, registered ack one clock after strobe
    // ***************************************************
    // A request is taken once: gating on ack keeps a held
    // strobe from writing again in the ack cycle
    assign bus_wr  = cyc_i && stb_i && we_i && !ack_o;
    assign menu_wr = (menu_reg != BZC_M_IDLE) && !locked && (key_up_i || key_down_i);

    // Write decode; a colors write needs both low lanes, while
    // setpoint and control writes need only lane 0
    logic sp_hit;
    logic col_hit;
    logic ctl_hit;
    assign sp_hit  = bus_wr && !locked && sel_i[0] && adr_i[7:4] == 4'h0 && adr_i[1:0] == 2'h0;
    assign col_hit = bus_wr && !locked && sel_i[1:0] == 2'h3 && adr_i == `BZC_OFF_COLORS;
    assign ctl_hit = bus_wr && !locked && sel_i[0] && adr_i == `BZC_OFF_CONTROL;

    // One-cycle ack, dropped in the cycle after it is given
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
        end else begin
            ack_o <= cyc_i && stb_i && !ack_o;
        end
    end

    // ***************************************************
    // Register file
    // ***************************************************
    // Setpoints; bus writes refused under lockout too
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < 4; i++) sp_reg[i] <= `BZC_SP_RESET;
        end else if (sp_hit) begin
            sp_reg[adr_i[3:2]] <= dat_i[W-1:0];
        end
    end

    // Colors: key stepping has priority over a bus write
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            colors_reg <= `BZC_COLORS_RESET;
        end else if (menu_wr) begin
            case (colors_reg[2*item +: 2])
                BZC_GREEN:  colors_reg[2*item +: 2] <= key_up_i ? BZC_ORANGE : BZC_RED;
                BZC_ORANGE: colors_reg[2*item +: 2] <= key_up_i ? BZC_RED : BZC_GREEN;
                default:    colors_reg[2*item +: 2] <= key_up_i ? BZC_GREEN : BZC_ORANGE;
            endcase
        end else if (col_hit) begin
            colors_reg <= dat_i[9:0];
        end
    end

    // Control: brightness and tricolor fitted
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctl_reg <= `BZC_CTL_RESET;
        end else if (ctl_hit) begin
            ctl_reg <= dat_i[2:0];
        end
    end

    // ***************************************************
    // Read path
    // ***************************************************
    // Reads stay open under lockout: viewing is allowed
    // Read mux
    always_comb begin
        rd_next = 32'h0;
        if (adr_i == `BZC_OFF_SP_ONE) begin
            rd_next = 32'(sp_reg[0]);
        end else if (adr_i == `BZC_OFF_SP_TWO) begin
            rd_next = 32'(sp_reg[1]);
        end else if (adr_i == `BZC_OFF_SP_THREE) begin
            rd_next = 32'(sp_reg[2]);
        end else if (adr_i == `BZC_OFF_SP_FOUR) begin
            rd_next = 32'(sp_reg[3]);
        end else if (adr_i == `BZC_OFF_COLORS) begin
            rd_next = {22'h0, colors_reg};
        end else if (adr_i == `BZC_OFF_CONTROL) begin
            rd_next = {29'h0, ctl_reg};
        end else if (adr_i == `BZC_OFF_STATUS) begin
            rd_next = {24'h0, locked, dimmed, menu_reg != BZC_M_IDLE, item, bar_color_o};
        end else if (adr_i == `BZC_OFF_POSITION) begin
            rd_next = 32'(pos_reg);
        end
    end

    // Read data registered, valid alongside ack
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_o <= 32'h0;
        end else begin
            dat_o <= rd_next;
        end
    end

endmodule // bzc_color_selector

// >>> bzc_color_selector_asserts.sv
`timescale 1ns/1ps
// ***************************************************
// Port-level checks of the color selector
// ***************************************************
module bzc_color_selector_asserts (
    // Clock and reset
    input wire logic       clk_i,
    input wire logic       rst_i,
    // Stimulus seen at the ports
    input wire logic       cyc_i,
    input wire logic       stb_i,
    input wire logic       update_i,
    input wire logic       key_prog_i,
    input wire logic       key_up_i,
    input wire logic       key_down_i,
    input wire logic       relay_menu_done_i,
    input wire logic       dim_n_i,
    // Outputs
    input wire logic       ack_o,
    input wire logic [1:0] bar_color_o,
    input wire logic [1:0] brightness_o,
    input wire logic [2:0] menu_item_o,
    input wire logic       menu_active_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    property p_one_color; bar_color_o != 2'h3; endproperty
    a_one_color: assert property (p_one_color) else $error("bar color code out of range");
    property p_color_cause;
        $changed(bar_color_o) |-> $past(update_i, 2) || $past(ack_o) || $past(key_up_i | key_down_i, 2);
    endproperty
    a_color_cause: assert property (p_color_cause) else $error("bar color changed without cause");
    property p_dim_half; !dim_n_i |=> brightness_o[1] == 1'b0; endproperty
    a_dim_half: assert property (p_dim_half) else $error("dim did not halve brightness");
    property p_menu_entry; $rose(menu_active_o) |-> $past(relay_menu_done_i, 2); endproperty
    a_menu_entry: assert property (p_menu_entry) else $error("menu entered without relay step");
    property p_advance;
        menu_active_o && key_prog_i && menu_item_o < 3'h4 |=> ##1 menu_item_o == $past(menu_item_o, 2) + 3'h1;
    endproperty
    a_advance: assert property (p_advance) else $error("program key did not advance item");
    property p_exit; menu_active_o && key_prog_i && menu_item_o == 3'h4 |=> ##1 !menu_active_o; endproperty
    a_exit: assert property (p_exit) else $error("menu not left after last item");
    property p_ack_answer; cyc_i && stb_i && !ack_o |=> ack_o; endproperty
    a_ack_answer: assert property (p_ack_answer) else $error("bus request not acknowledged");
    property p_ack_pulse; ack_o |=> !ack_o; endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("acknowledge longer than one cycle");
endmodule // bzc_color_selector_asserts

bind bzc_color_selector bzc_color_selector_asserts i_bzc_color_selector_asserts (.clk_i, .rst_i, .cyc_i,
    .stb_i, .update_i, .key_prog_i, .key_up_i, .key_down_i, .relay_menu_done_i, .dim_n_i, .ack_o,
    .bar_color_o, .brightness_o, .menu_item_o, .menu_active_o);

// >>> bzc_panel_model.sv
`timescale 1ns/1ps
// ***************************************************
// Front-panel keys and rear contacts
// ***************************************************
module bzc_panel_model (
    // Clock
    input  wire logic clk_i,
    // Keys, one-cycle pulses
    output logic      key_prog_o,
    output logic      key_up_o,
    output logic      key_down_o,
    output logic      relay_menu_done_o,
    // Rear contacts, low when tied to common
    output logic      lock_n_o,
    output logic      dim_n_o
);
    logic [3:0] keys = 4'h0;
    assign key_prog_o        = keys[0];
    assign key_up_o          = keys[1];
    assign key_down_o        = keys[2];
    assign relay_menu_done_o = keys[3];
    initial begin
        lock_n_o = 1'b1;
        dim_n_o  = 1'b1;
    end
    // Press one key for exactly one cycle, 0 prog 1 up 2 down 3 relay done
    task press(input int k);
        @(posedge clk_i);
        keys[k] <= 1'b1;
        @(posedge clk_i);
        keys <= 4'h0;
    endtask
    task contacts(input logic lock, input logic dim);
        @(posedge clk_i);
        lock_n_o <= !lock;
        dim_n_o  <= !dim;
    endtask
endmodule // bzc_panel_model

// >>> test_bzc_color_selector.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin fail_count++; \
    $display("wrong value %s expected %0h seen %0h", n, e, g); end end
module test_bzc_color_selector;
    import bzc_pkg::*;
    logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, upd = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0, bsel = 4'hf;
    logic [31:0] dat = 32'h0, rd, dat_o;
    logic signed [15:0] pos = 16'sh0;
    logic ack_o, kp, ku, kd, rmd, lk, dm, act, lbl;
    logic [1:0] bar, bri;
    logic [2:0] item;
    int fail_count = 0, comparisons = 0;
    logic signed [15:0] ptab [8] = '{0, 5, 6, 10, 11, 20, 21, -3};
    logic [1:0] ctab [8] = '{0, 0, 1, 1, 2, 2, 2, 0};
    always #20 clk_i = ~clk_i;
    bzc_panel_model i_bzc_panel_model (.clk_i(clk_i), .key_prog_o(kp), .key_up_o(ku), .key_down_o(kd),
        .relay_menu_done_o(rmd), .lock_n_o(lk), .dim_n_o(dm));
    bzc_color_selector #(.W(16), .BLINK_CY(4)) i_bzc_color_selector (.clk_i(clk_i), .rst_i(rst_i),
        .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(dat), .dat_o(dat_o),
        .ack_o(ack_o), .position_i(pos), .update_i(upd), .key_prog_i(kp), .key_up_i(ku), .key_down_i(kd),
        .relay_menu_done_i(rmd), .lock_n_i(lk), .dim_n_i(dm), .bar_color_o(bar), .brightness_o(bri),
        .show_label_o(lbl), .menu_item_o(item), .menu_active_o(act));
    // One classic cycle, held until ack is sampled
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we  <= w;
        adr <= a;
        dat <= d;
        sel <= bsel;
        do @(posedge clk_i); while (ack_o !== 1'b1);
        rd = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
    endtask
    task settle;
        repeat (3) @(posedge clk_i);
        #1;
    endtask
    task tally_and_finish;
        $display("comparisons %0d fail_count %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // Hang guard, far above the under two hundred cycles needed
    initial begin
        repeat (5000) @(posedge clk_i);
        fail_count++;
        tally_and_finish();
    end
    initial begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        bus(0, 8'h14, 0); `CHK("control", 32'h7, rd)
        bus(0, 8'h20, 0); `CHK("unmapped", 32'h0, rd)
        `CHK("brightness", 2'h3, bri)
        // Setpoint order differs from value order, two tied at 20
        foreach (ptab[i]) if (i < 4) bus(1, 8'(4 * i), (i == 0) ? 10 : (i == 3) ? 5 : 20);
        bus(1, 8'h10, 32'h198);
        for (int i = 0; i < 8; i++) begin
            @(posedge clk_i);
            pos <= ptab[i];
            upd <= 1'b1;
            @(posedge clk_i);
            upd <= 1'b0;
            settle();
            `CHK("bar color", ctab[i], bar)
        end
        i_bzc_panel_model.contacts(0, 1);
        settle(); `CHK("dimmed", 2'h1, bri)
        i_bzc_panel_model.contacts(0, 0);
        i_bzc_panel_model.press(3);
        settle(); `CHK("menu entry", 4'h8, {act, item})
        `CHK("label shown", 1'b1, lbl)
        repeat (4) @(posedge clk_i);
        #1;
        `CHK("label blink", 1'b0, lbl)
        i_bzc_panel_model.press(1);
        settle(); `CHK("bar after up", 2'h1, bar)
        i_bzc_panel_model.press(1); i_bzc_panel_model.press(1);
        bus(0, 8'h10, 0); `CHK("color wrap", 2'h0, rd[1:0])
        i_bzc_panel_model.press(2);
        bus(0, 8'h10, 0); `CHK("color down", 2'h2, rd[1:0])
        i_bzc_panel_model.contacts(1, 0);
        i_bzc_panel_model.press(1);
        bus(1, 8'h00, 32'h63);
        bus(0, 8'h10, 0); `CHK("locked key", 2'h2, rd[1:0])
        bus(0, 8'h00, 0); `CHK("locked write", 32'ha, rd)
        bus(0, 8'h18, 0); `CHK("status", 32'ha2, rd)
        bus(0, 8'h1c, 0); `CHK("position", 32'hfffffffd, rd)
        i_bzc_panel_model.contacts(0, 0);
        // A colors write without both low lanes is ignored
        bsel = 4'h1;
        bus(1, 8'h10, 32'h3ff);
        bsel = 4'hf;
        bus(0, 8'h10, 0); `CHK("byte lanes", 32'h19a, rd)
        for (int k = 1; k <= 5; k++) begin
            i_bzc_panel_model.press(0);
            settle(); `CHK("menu step", (k < 5) ? {1'b1, 3'(k)} : 4'h0, {act, item})
        end
        bus(1, 8'h14, 32'h3);
        i_bzc_panel_model.press(3);
        settle(); `CHK("mono menu", 1'b0, act)
        tally_and_finish();
    end
endmodule // test_bzc_color_selector
